/* File: pkg/wcas_map.svh */
// Purpose : register map, field positions and counts of the watch block
// Assumes : 32-bit register words on an 8-bit byte address
// Notes   : definitions only
`ifndef WCAS_MAP_SVH
`define WCAS_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define WCAS_A_CTRL   8'h00
`define WCAS_A_TIME   8'h04
`define WCAS_A_DAY    8'h08
`define WCAS_A_AL1    8'h0C
`define WCAS_A_AL2    8'h10
`define WCAS_A_AL2D   8'h14
`define WCAS_A_SW     8'h18
`define WCAS_A_STAT   8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WCAS_C_RUN    0
`define WCAS_C_IEN    7:1
`define WCAS_F_CTRL   7:0
`define WCAS_F_SEC    5:0
`define WCAS_F_MIN    13:8
`define WCAS_F_HOUR   20:16
`define WCAS_F_DAY    14:0
`define WCAS_F_SW     15:0
`define WCAS_F_STAT   6:0
`define WCAS_S_SEC    0
`define WCAS_S_MIN    1
`define WCAS_S_HOUR   2
`define WCAS_S_DAY    3
`define WCAS_S_AL1    4
`define WCAS_S_AL2    5
`define WCAS_S_SW     6

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define WCAS_CTRL_RST 8'h01
`define WCAS_SEC_MAX  6'h3B
`define WCAS_MIN_MAX  6'h3B
`define WCAS_HOUR_MAX 5'h17
`define WCAS_DAY_MAX  15'h7FFF
`define WCAS_PRE_LAST 15'h7FFF
`define WCAS_PRE_HALF 15'h3FFF
`define WCAS_SW_ONE   16'h0001

`endif

/* File: pkg/wcas_pkg.sv */
// Purpose : shared types of the watch block
// Assumes : nothing beyond the map header
// Notes   : widths fixed at the counter sizes
`default_nettype none
package wcas_pkg;
  typedef logic [5:0]  wcas_sec_t;
  typedef logic [5:0]  wcas_min_t;
  typedef logic [4:0]  wcas_hour_t;
  typedef logic [14:0] wcas_day_t;
  typedef logic [15:0] wcas_sw_t;
  typedef logic [6:0]  wcas_stat_t;
  typedef logic [7:0]  wcas_ctrl_t;

  // time of day as held for the alarms
  typedef struct packed {
    wcas_hour_t hour;
    wcas_min_t  min;
    wcas_sec_t  sec;
  } wcas_tod_t;

  typedef enum logic {WCAS_SW_IDLE, WCAS_SW_RUN} wcas_sw_state_t;
endpackage
`default_nettype wire

/* File: pkg/wcas_tick_if.sv */
// Purpose : carries the prescaled time base to the counter logic
// Assumes : one clock domain
// Notes   : both strobes are one-cycle pulses
`default_nettype none
interface wcas_tick_if;
  logic sec_tick;
  logic half_tick;
  modport src (output sec_tick, output half_tick);
  modport dst (input  sec_tick, input  half_tick);
endinterface
`default_nettype wire

/* File: src/wcas_modcnt.sv */
// Purpose : modulo counter with load and wrap carry
// Assumes : load has priority over increment
// Notes   : wrap_o is combinational, high with inc_i at the maximum and no ld_i
`default_nettype none
module wcas_modcnt #(
  parameter int unsigned W = 6,
  parameter logic [W-1:0] MAXV = '1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         inc_i,
  input  wire logic         ld_i,
  input  wire logic [W-1:0] ld_val_i,
  output logic      [W-1:0] val_o,
  output logic              wrap_o
);
  typedef struct packed {
    logic [W-1:0] val;
  } wcas_cnt_st_t;

  wcas_cnt_st_t s_q;
  wcas_cnt_st_t s_d;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (ld_i)
    begin
      // out-of-range loads would never wrap at the right place
      s_d.val = (ld_val_i > MAXV) ? '0 : ld_val_i;
    end
    else if (inc_i)
    begin
      s_d.val = (s_q.val == MAXV) ? '0 : s_q.val + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign val_o  = s_q.val;
  assign wrap_o = inc_i && !ld_i && (s_q.val == MAXV);
endmodule
`default_nettype wire

/* File: src/wcas_prescale.sv */
// Purpose : divides the sampled crystal input down to a 1 Hz tick
// Assumes : crystal input sampled directly, far slower than the clock
// Notes   : half_tick marks mid-second for the calibration output
`include "wcas_map.svh"
`default_nettype none
module wcas_prescale (
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  input  wire logic   xin_i,
  input  wire logic   run_i,
  wcas_tick_if.src    tick_o
);
  typedef struct packed {
    logic        xin_prev;
    logic [14:0] cnt;
    logic        tick;
    logic        half;
  } wcas_pre_st_t;

  wcas_pre_st_t s_q;
  wcas_pre_st_t s_d;
  logic         rise;

  // ----------------------------------------------------------------
  // count crystal edges, 32768 of them per second
  // ----------------------------------------------------------------
  assign rise = xin_i && !s_q.xin_prev;

  always_comb
  begin
    s_d          = s_q;
    s_d.xin_prev = xin_i;
    s_d.tick     = 1'b0;
    s_d.half     = 1'b0;
    // stopped prescaler keeps its phase so a restart is seamless
    if (rise && run_i)
    begin
      s_d.cnt  = s_q.cnt + 1'b1;
      s_d.tick = (s_q.cnt == `WCAS_PRE_LAST);
      s_d.half = (s_q.cnt == `WCAS_PRE_HALF);
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_o.sec_tick  = s_q.tick;
  assign tick_o.half_tick = s_q.half;
endmodule
`default_nettype wire

/* File: src/wcas_top.sv */
// Purpose : watch block with time keeping, two alarms and stopwatch
// Assumes : crystal input synchronous to SYS_CLK_I, plain register port
// Notes   : interrupt output is the OR of enabled sticky status bits
//
// Operation
// - crystal input divided by a prescaler down to a 1 Hz tick
// - seconds and minutes counters each count sixty states
// - hours counter counts 24 states, advanced by minutes wrap
// - day counter spans 32768 days, advanced by hours wrap
// - enabled alarm interrupts when a tick brings the counters to the alarm value
// - alarm one matches time of day, alarm two day plus time
// - stopwatch loaded by software, then decrements once per second
// - enabled stopwatch interrupts when its countdown underflows
// - selectable periodic interrupts on second, minute, hour, day
// - calibration output toggles twice per second from the time base, a 1 Hz square wave
// - counting and state persist while the host is in low power
`include "wcas_map.svh"
`default_nettype none
module wcas_top
  import wcas_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CRYSTAL_IN_PIN_I,
  output logic             CRYSTAL_OUT_PIN_O,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             IRQ_O,
  output logic             CALIB_SECOND_OUT_O
);

  // ----------------------------------------------------------------
  // state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    wcas_ctrl_t     ctrl;
    wcas_tod_t      al1;
    wcas_tod_t      al2;
    wcas_day_t      al2_day;
    wcas_sw_t       sw_cnt;
    wcas_sw_state_t sw_st;
    wcas_stat_t     stat;
    logic           chk;
    logic           irq;
    logic [31:0]    rdata;
    logic           calib;
    logic           xout;
  } wcas_top_st_t;

  wcas_top_st_t s_q;
  wcas_top_st_t s_d;

  wcas_tick_if  tick ();

  wcas_sec_t    sec_v;
  wcas_min_t    min_v;
  wcas_hour_t   hour_v;
  wcas_day_t    day_v;
  logic         sec_wrap;
  logic         min_wrap;
  logic         hour_wrap;
  logic         day_wrap;
  logic         ld_tod;
  logic         ld_day;
  wcas_tod_t    cur_tod;
  wcas_stat_t   ev;
  wcas_stat_t   clr;
  logic         al1_hit;
  logic         al2_hit;
  logic         sw_under;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  wcas_prescale u_pre (
    .clk_i  (SYS_CLK_I),
    .srst_i (SRST_I),
    .xin_i  (CRYSTAL_IN_PIN_I),
    .run_i  (s_q.ctrl[`WCAS_C_RUN]),
    .tick_o (tick.src)
  );

  // ----------------------------------------------------------------
  // cascaded time-keeping counters
  // ----------------------------------------------------------------
  // software loads of the counters
  assign ld_tod = WR_I && (ADDR_I == `WCAS_A_TIME);
  assign ld_day = WR_I && (ADDR_I == `WCAS_A_DAY);

  // no host power input gates these: they count on regardless
  wcas_modcnt #(.W(6), .MAXV(`WCAS_SEC_MAX)) u_sec (
    .clk_i    (SYS_CLK_I),
    .srst_i   (SRST_I),
    .inc_i    (tick.sec_tick),
    .ld_i     (ld_tod),
    .ld_val_i (WDATA_I[`WCAS_F_SEC]),
    .val_o    (sec_v),
    .wrap_o   (sec_wrap)
  );

  wcas_modcnt #(.W(6), .MAXV(`WCAS_MIN_MAX)) u_min (
    .clk_i    (SYS_CLK_I),
    .srst_i   (SRST_I),
    .inc_i    (sec_wrap),
    .ld_i     (ld_tod),
    .ld_val_i (WDATA_I[`WCAS_F_MIN]),
    .val_o    (min_v),
    .wrap_o   (min_wrap)
  );

  wcas_modcnt #(.W(5), .MAXV(`WCAS_HOUR_MAX)) u_hour (
    .clk_i    (SYS_CLK_I),
    .srst_i   (SRST_I),
    .inc_i    (min_wrap),
    .ld_i     (ld_tod),
    .ld_val_i (WDATA_I[`WCAS_F_HOUR]),
    .val_o    (hour_v),
    .wrap_o   (hour_wrap)
  );

  // the day count simply rolls over after its last day
  wcas_modcnt #(.W(15), .MAXV(`WCAS_DAY_MAX)) u_day (
    .clk_i    (SYS_CLK_I),
    .srst_i   (SRST_I),
    .inc_i    (hour_wrap),
    .ld_i     (ld_day),
    .ld_val_i (WDATA_I[`WCAS_F_DAY]),
    .val_o    (day_v),
    .wrap_o   (day_wrap)
  );

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  assign cur_tod = '{hour: hour_v, min: min_v, sec: sec_v};

  // compared one cycle after the tick, once the counters have moved;
  // a match made by a software load alone raises nothing
  assign al1_hit = s_q.chk && (cur_tod == s_q.al1);
  assign al2_hit = s_q.chk && (cur_tod == s_q.al2)
                   && (day_v == s_q.al2_day);

  assign sw_under = tick.sec_tick && (s_q.sw_st == WCAS_SW_RUN)
                    && (s_q.sw_cnt == '0);

  // event vector in status bit order
  always_comb
  begin
    ev                = '0;
    ev[`WCAS_S_SEC]   = tick.sec_tick;
    ev[`WCAS_S_MIN]   = sec_wrap;
    ev[`WCAS_S_HOUR]  = min_wrap;
    ev[`WCAS_S_DAY]   = hour_wrap;
    ev[`WCAS_S_AL1]   = al1_hit;
    ev[`WCAS_S_AL2]   = al2_hit;
    ev[`WCAS_S_SW]    = sw_under;
  end

  // write-one-to-clear of the status register
  assign clr = (WR_I && (ADDR_I == `WCAS_A_STAT))
               ? WDATA_I[`WCAS_F_STAT] : '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d       = s_q;
    s_d.chk   = tick.sec_tick;
    s_d.rdata = '0;
    s_d.xout  = !CRYSTAL_IN_PIN_I;

    // register writes
    if (WR_I)
    begin
      case (ADDR_I)
        `WCAS_A_CTRL:
        begin
          s_d.ctrl = WDATA_I[`WCAS_F_CTRL];
        end
        `WCAS_A_AL1:
        begin
          s_d.al1.sec  = WDATA_I[`WCAS_F_SEC];
          s_d.al1.min  = WDATA_I[`WCAS_F_MIN];
          s_d.al1.hour = WDATA_I[`WCAS_F_HOUR];
        end
        `WCAS_A_AL2:
        begin
          s_d.al2.sec  = WDATA_I[`WCAS_F_SEC];
          s_d.al2.min  = WDATA_I[`WCAS_F_MIN];
          s_d.al2.hour = WDATA_I[`WCAS_F_HOUR];
        end
        `WCAS_A_AL2D:
        begin
          s_d.al2_day = WDATA_I[`WCAS_F_DAY];
        end
        default:
        begin
          s_d.ctrl = s_q.ctrl;
        end
      endcase
    end

    // stopwatch; a load in the tick cycle wins over the decrement
    case (s_q.sw_st)
      WCAS_SW_IDLE:
      begin
        s_d.sw_st = WCAS_SW_IDLE;
      end
      WCAS_SW_RUN:
      begin
        if (tick.sec_tick)
        begin
          if (s_q.sw_cnt == '0)
            s_d.sw_st = WCAS_SW_IDLE;
          else
            s_d.sw_cnt = s_q.sw_cnt - `WCAS_SW_ONE;
        end
      end
      default:
      begin
        s_d.sw_st = WCAS_SW_IDLE;
      end
    endcase
    if (WR_I && (ADDR_I == `WCAS_A_SW))
    begin
      s_d.sw_cnt = WDATA_I[`WCAS_F_SW];
      s_d.sw_st  = WCAS_SW_RUN;
    end

    // sticky flags: a new event beats a clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | ev;
    // disabled sources stay visible in status but never interrupt
    s_d.irq  = |(s_d.stat & s_q.ctrl[`WCAS_C_IEN]);

    // square wave, one full period per second
    if (tick.sec_tick || tick.half_tick)
      s_d.calib = !s_q.calib;

    // read data, present only in the cycle after the strobe
    if (RD_I)
    begin
      case (ADDR_I)
        `WCAS_A_CTRL:
          s_d.rdata[`WCAS_F_CTRL] = s_q.ctrl;
        `WCAS_A_TIME:
        begin
          s_d.rdata[`WCAS_F_SEC]  = sec_v;
          s_d.rdata[`WCAS_F_MIN]  = min_v;
          s_d.rdata[`WCAS_F_HOUR] = hour_v;
        end
        `WCAS_A_DAY:
          s_d.rdata[`WCAS_F_DAY] = day_v;
        `WCAS_A_AL1:
        begin
          s_d.rdata[`WCAS_F_SEC]  = s_q.al1.sec;
          s_d.rdata[`WCAS_F_MIN]  = s_q.al1.min;
          s_d.rdata[`WCAS_F_HOUR] = s_q.al1.hour;
        end
        `WCAS_A_AL2:
        begin
          s_d.rdata[`WCAS_F_SEC]  = s_q.al2.sec;
          s_d.rdata[`WCAS_F_MIN]  = s_q.al2.min;
          s_d.rdata[`WCAS_F_HOUR] = s_q.al2.hour;
        end
        `WCAS_A_AL2D:
          s_d.rdata[`WCAS_F_DAY] = s_q.al2_day;
        `WCAS_A_SW:
          s_d.rdata[`WCAS_F_SW] = s_q.sw_cnt;
        `WCAS_A_STAT:
          s_d.rdata[`WCAS_F_STAT] = s_q.stat;
        default:
          s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      s_q      <= '0;
      s_q.ctrl <= `WCAS_CTRL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign RDATA_O            = s_q.rdata;
  assign IRQ_O              = s_q.irq;
  assign CALIB_SECOND_OUT_O = s_q.calib;
  assign CRYSTAL_OUT_PIN_O  = s_q.xout;

  // day wrap has no consumer beyond the counter itself
  logic unused_day_wrap;
  assign unused_day_wrap = day_wrap;
endmodule
`default_nettype wire

/* File: tb/wcas_monitor.sv */
// Purpose : port-level checks of the watch block
// Assumes : sees only the top ports, one clock domain
// Notes   : bound into wcas_top after the module
`include "wcas_map.svh"
`default_nettype none
module wcas_monitor (
  input wire logic        SYS_CLK_I,
  input wire logic        SRST_I,
  input wire logic        CRYSTAL_IN_PIN_I,
  input wire logic        CRYSTAL_OUT_PIN_O,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        IRQ_O,
  input wire logic        CALIB_SECOND_OUT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);

  // read data only in the slot after a read strobe
  a_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data not zero outside read slot");
  a_unmapped_rd: assert property (
    RD_I && ADDR_I > `WCAS_A_STAT |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_time_range: assert property (
    RD_I && ADDR_I == `WCAS_A_TIME |=> RDATA_O[5:0] <= `WCAS_SEC_MAX
    && RDATA_O[13:8] <= `WCAS_MIN_MAX && RDATA_O[20:16] <= `WCAS_HOUR_MAX
    && RDATA_O[31:21] == 11'h0)
    else $error("time field out of range");
  a_day_width: assert property (
    RD_I && ADDR_I == `WCAS_A_DAY |=> RDATA_O[31:15] == 17'h0)
    else $error("day wider than fifteen bits");
  a_stat_width: assert property (
    RD_I && ADDR_I == `WCAS_A_STAT |=> RDATA_O[31:7] == 25'h0)
    else $error("status wider than seven bits");
  // enables off must silence the line two cycles on
  a_irq_masked: assert property (
    WR_I && ADDR_I == `WCAS_A_CTRL && WDATA_I[7:1] == 7'h0 |-> ##2 !IRQ_O)
    else $error("interrupt with all enables off");
  // a status clear drops the line one cycle on, an enable write two
  a_irq_sticky: assert property (
    $fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
    else $error("interrupt dropped without a write");
  // half a second is far beyond eight clocks
  a_calib_slow: assert property (
    $changed(CALIB_SECOND_OUT_O) |=> $stable(CALIB_SECOND_OUT_O)[*8])
    else $error("calibration output toggles too fast");
  a_calib_cause: assert property (
    $stable(CRYSTAL_IN_PIN_I)[*6] |-> $stable(CALIB_SECOND_OUT_O))
    else $error("calibration moved without crystal edges");
  a_xtal_fb: assert property (
    !SRST_I |=> CRYSTAL_OUT_PIN_O == !$past(CRYSTAL_IN_PIN_I))
    else $error("oscillator feedback not inverse of input");

  c_irq_rise: cover property ($rose(IRQ_O));
  c_calib_edge: cover property ($changed(CALIB_SECOND_OUT_O));
  c_time_read: cover property (RD_I && ADDR_I == `WCAS_A_TIME);
endmodule

bind wcas_top wcas_monitor u_mon (
  .SYS_CLK_I          (SYS_CLK_I),
  .SRST_I             (SRST_I),
  .CRYSTAL_IN_PIN_I   (CRYSTAL_IN_PIN_I),
  .CRYSTAL_OUT_PIN_O  (CRYSTAL_OUT_PIN_O),
  .ADDR_I             (ADDR_I),
  .WDATA_I            (WDATA_I),
  .WR_I               (WR_I),
  .RD_I               (RD_I),
  .RDATA_O            (RDATA_O),
  .IRQ_O              (IRQ_O),
  .CALIB_SECOND_OUT_O (CALIB_SECOND_OUT_O)
);
`default_nettype wire

/* File: tb/wcas_tb_top.sv */
// Purpose : self-checking bench of the watch block
// Assumes : crystal model, one full second of edges
// Notes   : about 66k clocks, dominated by that second
`include "wcas_map.svh"
`default_nettype none
module wcas_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [6:0] STAT_EXP = 7'h5F;
  logic        sys_clk;
  logic        srst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        xtal_en;
  logic        xin;
  int unsigned edges;
  logic [31:0] rdata;
  logic        irq;
  logic        calib;
  int          fails;
  int          n_compared;

  wcas_xtal_model u_xtal (
    .clk_i   (sys_clk),
    .en_i    (xtal_en),
    .xin_o   (xin),
    .edges_o (edges)
  );

  wcas_top uut (
    .SYS_CLK_I          (sys_clk),
    .SRST_I             (srst),
    .CRYSTAL_IN_PIN_I   (xin),
    .CRYSTAL_OUT_PIN_O  (),
    .ADDR_I             (addr),
    .WDATA_I            (wdata),
    .WR_I               (wr),
    .RD_I               (rd),
    .RDATA_O            (rdata),
    .IRQ_O              (irq),
    .CALIB_SECOND_OUT_O (calib)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic clk_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask

  // bounded wait, a stuck model ends the run
  task automatic wait_edges(input int unsigned n);
    int k;
    k = 0;
    while (edges < n && k < 40000)
    begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    if (edges < n)
    begin
      fails++;
      $display("Error crystal edges expected %0d seen %0d", n, edges);
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fails      = 0;
    n_compared = 0;
    srst       = 1'b1;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    xtal_en    = 1'b0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(`WCAS_A_CTRL, 32'h00000001, "ctrl reset");
    rd_reg(`WCAS_A_TIME, 32'h0, "time reset");
    rd_reg(`WCAS_A_STAT, 32'h0, "status reset");
    rd_reg(8'h20, 32'h0, "unmapped read");
    $display("test reset done");
    // last second of the last day, alarm one at midnight
    wr_reg(`WCAS_A_CTRL, 32'h00000001);
    wr_reg(`WCAS_A_TIME, 32'h00173B3B);
    wr_reg(`WCAS_A_DAY, 32'h00007FFF);
    wr_reg(`WCAS_A_AL1, 32'h0);
    wr_reg(`WCAS_A_AL2, 32'h0);
    wr_reg(`WCAS_A_AL2D, 32'h00000001);
    wr_reg(`WCAS_A_SW, 32'h0);
    wr_reg(8'h24, 32'hFFFFFFFF);
    rd_reg(`WCAS_A_TIME, 32'h00173B3B, "time load");
    rd_reg(`WCAS_A_DAY, 32'h00007FFF, "day load");
    rd_reg(`WCAS_A_STAT, 32'h0, "no alarm on load");
    $display("test load done");
    xtal_en <= 1'b1;
    wait_edges(16400);
    chk("calib mid", {31'h0, calib}, 32'h1);
    wait_edges(32768);
    xtal_en <= 1'b0;
    clk_n(10);
    chk("calib second", {31'h0, calib}, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd_reg(`WCAS_A_TIME, 32'h0, "time wrap");
    rd_reg(`WCAS_A_DAY, 32'h0, "day wrap");
    rd_reg(`WCAS_A_STAT, 32'h5F, "status");
    rd_reg(`WCAS_A_SW, 32'h0, "sw underflow");
    wr_reg(`WCAS_A_SW, 32'h00000005);
    rd_reg(`WCAS_A_SW, 32'h5, "sw load");
    $display("test second done");
    // each source alone on the line, only set ones raise it
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(`WCAS_A_CTRL, 32'h1 | (32'h2 << i));
      clk_n(2);
      chk("irq source", {31'h0, irq}, {31'h0, STAT_EXP[i]});
    end
    // pending sources with every enable off must drop the line
    wr_reg(`WCAS_A_CTRL, 32'h00000001);
    clk_n(2);
    chk("irq all off", {31'h0, irq}, 32'h0);
    wr_reg(`WCAS_A_CTRL, 32'h000000FF);
    wr_reg(`WCAS_A_STAT, 32'h00000010);
    rd_reg(`WCAS_A_STAT, 32'h4F, "clear alarm");
    chk("irq held", {31'h0, irq}, 32'h1);
    wr_reg(`WCAS_A_STAT, 32'h0000007F);
    clk_n(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd_reg(`WCAS_A_STAT, 32'h0, "clear all");
    rd_reg(`WCAS_A_TIME, 32'h0, "time kept");
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: tb/wcas_xtal_model.sv */
// Purpose : behavioural crystal oscillator at the watch block pin
// Assumes : one rising edge each two system clocks
// Notes   : sped up from 32 kHz so a second fits the run
`default_nettype none
module wcas_xtal_model (
  input  wire logic   clk_i,
  input  wire logic   en_i,
  output logic        xin_o,
  output int unsigned edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  initial
  begin
    xin_o   = 1'b0;
    edges_o = 0;
  end

  // one clock per level keeps a full second under the run budget;
  // the sampler still sees every rising edge
  always @(posedge clk_i)
    if (en_i)
    begin
      xin_o <= ~xin_o;
      if (!xin_o)
        edges_o <= edges_o + 1;
    end
endmodule
`default_nettype wire
